// *** nvmac_pkg.sv ***
// package: constants and types for the byte-wide nvm access controller
package nvmac_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h40;
  localparam logic [7:0] CTRL_BANK = 8'h01;
  localparam logic [7:0] ADDR_OFFSET = 8'h00;
  localparam logic [7:0] DATA_OFFSET = 8'h01;
  localparam logic [7:0] DATA_BANK = 8'h00;
  localparam int unsigned BIT_RD = 0;
  localparam int unsigned BIT_RDP = 1;
  localparam int unsigned BIT_WR = 2;
  localparam int unsigned BIT_WRP = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int unsigned READ_NS = 8;
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] READ_CYC_W = 4'(READ_CYC);
  localparam logic [3:0] CNT_ONE = 4'h1;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] bank;
    logic [7:0] addr;
    logic [7:0] data;
  } nvmac_bus_t;

  typedef struct packed {
    logic start;
    logic [7:0] addr;
    logic [7:0] data;
  } nvmac_prog_t;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} nvmac_state_t;
endpackage : nvmac_pkg

// *** nvmac_ctrl.sv ***
// nvm byte access controller: registers, array and cycle sequencer
`timescale 1ns/1ps
module nvmac_ctrl #(
  parameter int unsigned DEPTH = 256
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // cpu register access
  input wire nvmac_pkg::nvmac_bus_t BUS,
  output logic [7:0] RDATA,
  // programming timer
  output nvmac_pkg::nvmac_prog_t PROG,
  input wire logic PROG_DONE,
  // completion flag and busy status
  input wire logic DONE_CLR,
  output logic DONE_FLAG,
  output logic BUSY
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [7:0] AMASK = 8'((DEPTH - 1) & 8'hFF);
  localparam logic [3:0] CNT_ONE_L = nvmac_pkg::CNT_ONE;

  // array image; contents survive reset like the cells
  logic [7:0] mem [DEPTH];
  logic [7:0] nvm_address;
  logic [7:0] nvm_data;
  logic write_permit;
  logic read_permit;
  logic wr_start;
  logic rd_start;
  logic [7:0] cap_addr;
  // read cycle countdown; reads need no timer
  logic [3:0] cnt;
  nvmac_pkg::nvmac_state_t state;
  logic sel_ctrl;
  logic sel_addr;
  logic sel_data;
  logic go_wr;
  logic go_rd;
  logic fin_rd;
  logic fin_wr;
  logic [7:0] ctrl_rd;

  assign sel_ctrl = BUS.bank == nvmac_pkg::CTRL_BANK &&
                    BUS.addr == nvmac_pkg::CTRL_OFFSET;
  assign sel_addr = BUS.bank == nvmac_pkg::DATA_BANK &&
                    BUS.addr == nvmac_pkg::ADDR_OFFSET;
  assign sel_data = BUS.bank == nvmac_pkg::DATA_BANK &&
                    BUS.addr == nvmac_pkg::DATA_OFFSET;
  // permit must already be set; a write also sets no start when busy
  assign go_wr = BUS.wr && sel_ctrl && BUS.data[nvmac_pkg::BIT_WR] &&
                 write_permit && state == nvmac_pkg::ST_IDLE;
  assign go_rd = BUS.wr && sel_ctrl && BUS.data[nvmac_pkg::BIT_RD] &&
                 read_permit && !go_wr &&
                 state == nvmac_pkg::ST_IDLE;
  assign fin_rd = state == nvmac_pkg::ST_READ && cnt == CNT_ONE_L;
  assign fin_wr = state == nvmac_pkg::ST_WRITE && PROG_DONE;

  always_comb begin
    ctrl_rd = nvmac_pkg::ZERO_BYTE;
    ctrl_rd[nvmac_pkg::BIT_WRP] = write_permit;
    ctrl_rd[nvmac_pkg::BIT_WR] = wr_start;
    ctrl_rd[nvmac_pkg::BIT_RDP] = read_permit;
    ctrl_rd[nvmac_pkg::BIT_RD] = rd_start;
  end

  // sequencer
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= nvmac_pkg::ST_IDLE;
      cnt <= 4'h0;
      cap_addr <= nvmac_pkg::ZERO_BYTE;
    end else begin
      case (state)
        nvmac_pkg::ST_IDLE: begin
          if (go_wr) begin
            state <= nvmac_pkg::ST_WRITE;
            cap_addr <= nvm_address;
          end else if (go_rd) begin
            state <= nvmac_pkg::ST_READ;
            cap_addr <= nvm_address;
            cnt <= nvmac_pkg::READ_CYC_W;
          end
        end
        nvmac_pkg::ST_READ: begin
          cnt <= cnt - CNT_ONE_L;
          if (fin_rd) begin
            state <= nvmac_pkg::ST_IDLE;
          end
        end
        nvmac_pkg::ST_WRITE: begin
          if (fin_wr) begin
            state <= nvmac_pkg::ST_IDLE;
          end
        end
        default: state <= nvmac_pkg::ST_IDLE;
      endcase
    end
  end

  // control register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      write_permit <= 1'b0;
      read_permit <= 1'b0;
      wr_start <= 1'b0;
      rd_start <= 1'b0;
    end else begin
      if (BUS.wr && sel_ctrl) begin
        write_permit <= BUS.data[nvmac_pkg::BIT_WRP];
        read_permit <= BUS.data[nvmac_pkg::BIT_RDP];
      end
      // software cannot clear a running start bit
      if (go_wr) begin
        wr_start <= 1'b1;
      end else if (fin_wr) begin
        wr_start <= 1'b0;
      end
      if (go_rd) begin
        rd_start <= 1'b1;
      end else if (fin_rd) begin
        rd_start <= 1'b0;
      end
    end
  end

  // address and data registers; reset value is a choice, array x is not
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      nvm_address <= nvmac_pkg::ZERO_BYTE;
      nvm_data <= nvmac_pkg::ZERO_BYTE;
    end else begin
      if (BUS.wr && sel_addr) begin
        nvm_address <= BUS.data & AMASK;
      end
      if (fin_rd) begin
        nvm_data <= mem[cap_addr[AW-1:0]];
      end else if (BUS.wr && sel_data && state != nvmac_pkg::ST_WRITE) begin
        nvm_data <= BUS.data;
      end
    end
  end

  // array image: updated when the timer reports the write done
  always_ff @(posedge CLK) begin
    if (fin_wr) begin
      mem[cap_addr[AW-1:0]] <= nvm_data;
    end
  end

  // read data: registered, stands until the next read
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= nvmac_pkg::ZERO_BYTE;
    end else if (BUS.rd) begin
      if (sel_ctrl) begin
        RDATA <= ctrl_rd;
      end else if (sel_addr) begin
        RDATA <= nvm_address;
      end else if (sel_data) begin
        RDATA <= nvm_data;
      end else begin
        RDATA <= nvmac_pkg::ZERO_BYTE;
      end
    end
  end

  // timer request; address and data stand till next start
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PROG <= '0;
    end else begin
      PROG.start <= go_wr;
      if (go_wr) begin
        PROG.addr <= nvm_address;
        PROG.data <= nvm_data;
      end
    end
  end

  // completion flag; a completion in the clearing cycle wins
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      DONE_FLAG <= 1'b0;
    end else if (fin_rd || fin_wr) begin
      DONE_FLAG <= 1'b1;
    end else if (DONE_CLR) begin
      DONE_FLAG <= 1'b0;
    end
  end

  // busy mirrors the state the sequencer enters at this edge
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= (state != nvmac_pkg::ST_IDLE && !fin_rd && !fin_wr) ||
              go_wr || go_rd;
    end
  end
endmodule : nvmac_ctrl

// *** nvmac_ctrl_props.sv ***
// checker: port properties of the nvm access controller
`timescale 1ns/1ps
module nvmac_ctrl_props (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // watched ports
  input wire nvmac_pkg::nvmac_bus_t BUS,
  input wire logic [7:0] RDATA,
  input wire nvmac_pkg::nvmac_prog_t PROG,
  input wire logic PROG_DONE,
  input wire logic DONE_CLR,
  input wire logic DONE_FLAG,
  input wire logic BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_prog_pulse: assert property (PROG.start |=> !PROG.start)
    else $error("start pulse too long");
  a_wr_hold: assert property (
    PROG.start ##1 !PROG_DONE [*3] |-> BUSY) else $error("write ended early");
  a_wr_finish: assert property (PROG_DONE && BUSY |=> !BUSY)
    else $error("write not ended by timer");
  a_read_len: assert property (
    ($rose(BUSY) && !PROG.start) ##1 BUSY |=> !BUSY)
    else $error("read length wrong");
  a_flag_set: assert property ($fell(BUSY) |=> DONE_FLAG)
    else $error("done flag not raised");
  a_flag_clr: assert property (
    DONE_CLR && !BUSY |=> !DONE_FLAG) else $error("flag not cleared");
  a_ctrl_upper: assert property (
    BUS.rd && BUS.bank == 8'h01 && BUS.addr == 8'h40 |=> RDATA[7:4] == 4'h0)
    else $error("control upper bits set");
  a_rdata_hold: assert property (!BUS.rd |=> $stable(RDATA))
    else $error("read data moved");
endmodule : nvmac_ctrl_props
bind nvmac_ctrl nvmac_ctrl_props nvmac_ctrl_props_i (.CLK, .RST_B, .BUS,
  .RDATA, .PROG, .PROG_DONE, .DONE_CLR, .DONE_FLAG, .BUSY);

// *** nvmac_timer_model.sv ***
// partner: programming timer that ends a write after a set delay
`timescale 1ns/1ps
module nvmac_timer_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic start,
  input wire logic [7:0] delay,
  output logic done
);
  logic [7:0] left;
  // counts on its own, blind to cpu accesses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= left == 8'h01;
      left <= start ? delay : left - 8'(left != 8'h00);
    end
  end
endmodule : nvmac_timer_model

// *** nvmac_ctrl_bench.sv ***
// bench: register traffic checked against a reference byte array
`timescale 1ns/1ps
module nvmac_ctrl_bench;
  localparam int DEPTH = 64;
  logic CLK = 0, RST_B = 0, DONE_CLR = 0, PROG_DONE, DONE_FLAG, BUSY;
  nvmac_pkg::nvmac_bus_t BUS = '0;
  nvmac_pkg::nvmac_prog_t PROG;
  logic [7:0] RDATA, d, dly = 8'h08;
  logic [7:0] tv [6] = '{8'h04, 8'h01, 8'hF2, 8'h0C, 8'h03, 8'h00};
  logic [7:0] te [6] = '{8'h00, 8'h00, 8'h02, 8'h08, 8'h02, 8'h00};
  int n_fail = 0, n_tests = 0, cyc = 0, mem [256], a, v;
  always #2 CLK = ~CLK;
  nvmac_ctrl #(.DEPTH(DEPTH)) nvmac_ctrl_i (.CLK, .RST_B, .BUS, .RDATA,
    .PROG, .PROG_DONE, .DONE_CLR, .DONE_FLAG, .BUSY);
  nvmac_timer_model nvmac_timer_model_i (.clk(CLK), .rst_b(RST_B),
    .start(PROG.start), .delay(dly), .done(PROG_DONE));
  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one access, then one edge more so read data has landed
  task automatic acc(input logic w, input logic [7:0] bk, ad, dt);
    @(posedge CLK);
    BUS <= {w, !w, bk, ad, dt};
    @(posedge CLK);
    BUS <= '0;
    @(posedge CLK);
    #1 d = RDATA;
  endtask : acc
  task automatic ctl(input logic [7:0] c);
    acc(1'b1, 8'h01, 8'h40, c);
  endtask : ctl
  task automatic poll(input int b);
    for (int i = 0; i < 40; i++) begin
      acc(1'b0, 8'h01, 8'h40, 8'h00);
      if (d[b] === 1'b0) break;
    end
    chk({7'h00, d[b]}, 8'h00);
  endtask : poll
  task automatic flag;
    chk({7'h00, DONE_FLAG}, 8'h01);
    @(posedge CLK);
    DONE_CLR <= 1'b1;
    @(posedge CLK);
    DONE_CLR <= 1'b0;
    @(posedge CLK);
    #1 chk({7'h00, DONE_FLAG}, 8'h00);
  endtask : flag
  task automatic summarize;
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      $display("unexpected at %0t: cycles %h limit %h", $time, cyc, 30000);
      summarize();
    end
  end
  initial begin
    v = $urandom(47817);
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    acc(1'b0, 8'h01, 8'h40, 8'h00);
    chk(d, 8'h00);
    acc(1'b0, 8'h00, 8'h05, 8'h00);
    chk(d, 8'h00);
    for (int i = 0; i < 6; i++) begin
      ctl(tv[i]);
      acc(1'b0, 8'h01, 8'h40, 8'h00);
      chk(d, te[i]);
      chk({7'h00, BUSY}, 8'h00);
    end
    repeat (20) begin
      a = $urandom_range(255);
      v = $urandom_range(255);
      dly <= 8'($urandom_range(23, 8));
      acc(1'b1, 8'h00, 8'h00, 8'(a));
      acc(1'b0, 8'h00, 8'h00, 8'h00);
      chk(d, 8'(a % DEPTH));
      acc(1'b1, 8'h00, 8'h01, 8'(v));
      ctl(8'h08);
      ctl(8'h0C);
      acc(1'b0, 8'h01, 8'h40, 8'h00);
      chk(d, 8'h0C);
      chk({7'h00, BUSY}, 8'h01);
      chk(PROG.addr, 8'(a % DEPTH));
      chk(PROG.data, 8'(v));
      acc(1'b1, 8'h00, 8'h01, 8'(~v));
      poll(2);
      mem[a % DEPTH] = v;
      acc(1'b0, 8'h00, 8'h01, 8'h00);
      chk(d, 8'(v));
      flag();
      ctl(8'h02);
      acc(1'b1, 8'h00, 8'h00, 8'((a + DEPTH) % 256));
      ctl(8'h03);
      poll(0);
      acc(1'b0, 8'h00, 8'h01, 8'h00);
      chk(d, 8'(mem[a % DEPTH]));
      flag();
    end
    summarize();
  end
endmodule : nvmac_ctrl_bench
